// [rtl/sftr_engine.sv]
`default_nettype none
module sftr_engine (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic txd_o,
   output logic txd_oe,
   input wire logic rxd_i,
   output logic xck_o,
   output logic xck_oe
);
   import sftr_pkg::*;

   // axi write and read channel latches
   logic aw_q, w_q;
   logic [7:0] awa_q;
   logic [31:0] wd_q;
   logic [3:0] ws_q;
   logic [1:0] bresp_q;
   logic bvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic rvalid_q;
   // configuration
   logic [7:0] ctrl_b_q, ctrl_c_q;
   logic [15:0] baud_q, tick_cnt_q;
   logic tx_hi_q;
   // transmit state
   sftr_tx_t tx_st_q;
   logic [8:0] tx_buf_q, tx_sh_q;
   logic tx_full_q, tx_par_q, tx_stop2_q, tx_on_q, txc_q;
   logic [3:0] tx_idx_q;
   logic [4:0] tx_smp_q;
   logic txd_q, xck_q;
   logic [7:0] spi_rx_q;
   // receive state
   sftr_rx_t rx_st_q;
   logic [2:0] rx_sync_q;
   logic rx_line_q, rx_prev_q;
   logic [4:0] rx_smp_q;
   logic [3:0] rx_idx_q;
   logic [1:0] vote_q;
   logic [8:0] rx_dat_q;
   logic rx_pbit_q, lin_pid_q;
   logic [11:0] ent_q [2];
   logic [1:0] cnt_q;
   logic rd_q;

   // decoded configuration
   wire spi = ctrl_c_q[7:6] == MODE_SPI;
   wire par_en = ctrl_c_q[5] && !spi;
   wire par_odd = ctrl_c_q[5:4] == PAR_ODD;
   wire lsb_first = !spi || ctrl_c_q[CC_ORDER];
   wire rx_en = ctrl_b_q[CB_RXEN];
   wire tx_en = ctrl_b_q[CB_TXEN];
   wire [4:0] smp_per_bit = ctrl_b_q[CB_DBL] ? SMP_DBL : SMP_NORM;
   wire [4:0] smp_mid = {1'b0, smp_per_bit[4:1]};
   wire [3:0] nbits = spi ? 4'h8 : (ctrl_c_q[2:0] == SIZE_9) ? 4'h9
                     : {2'h0, ctrl_c_q[1:0]} + 4'h5;
   wire [8:0] dmask = 9'h1FF >> (4'h9 - nbits);
   wire tick = tick_cnt_q == baud_q;

   // axi decode
   wire wr_go = aw_q && w_q && !bvalid_q;
   wire rd_go = s_axi_arvalid && !rvalid_q;
   wire wr_map = awa_q[7:5] == 3'h0 && awa_q[1:0] == 2'h0;
   wire rd_map = s_axi_araddr[7:5] == 3'h0 && s_axi_araddr[1:0] == 2'h0;
   wire wr_b0 = wr_go && ws_q[0];
   wire wr_txl = wr_b0 && awa_q == OFS_TX_LOW;
   wire wr_txh = wr_b0 && awa_q == OFS_TX_HIGH;
   wire wr_st = wr_b0 && awa_q == OFS_STATUS;
   wire wr_cb = wr_b0 && awa_q == OFS_CTRL_B;
   wire wr_cc = wr_b0 && awa_q == OFS_CTRL_C;
   wire wr_bd = wr_go && awa_q == OFS_BAUD;
   wire pop = rd_go && s_axi_araddr == OFS_RX_LOW && cnt_q != 2'h0;
   wire [11:0] head = ent_q[rd_q];
   wire rxc = cnt_q != 2'h0;
   wire dre = !tx_full_q;

   assign s_axi_awready = !aw_q;
   assign s_axi_wready = !w_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rvalid = rvalid_q;

   // read mux, upper bits zero
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0000_0000;
      case (s_axi_araddr)
         OFS_RX_LOW: rmux[7:0] = head[7:0];
         OFS_RX_HIGH: begin
            rmux[RH_D8] = head[8];
            rmux[RH_PARITY_ERROR_FLAG] = head[9];
            rmux[RH_FRAME_ERROR_FLAG] = head[10];
            rmux[RH_OVF] = head[11];
            rmux[RH_RXC] = rxc;
         end
         OFS_TX_HIGH: rmux[0] = tx_hi_q;
         OFS_STATUS: begin
            rmux[ST_RXC] = rxc;
            rmux[ST_TXC] = txc_q;
            rmux[ST_DRE] = dre;
         end
         OFS_CTRL_B: rmux[7:0] = ctrl_b_q;
         OFS_CTRL_C: rmux[7:0] = ctrl_c_q;
         OFS_BAUD: rmux[15:0] = baud_q;
         default: rmux = 32'h0000_0000;
      endcase
   end

   // address and data are taken in either order; response once both held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awa_q <= 8'h00;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OK;
      end else begin
         if (s_axi_awvalid && !aw_q) begin
            aw_q <= 1'b1;
            awa_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_q) begin
            w_q <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_map ? RESP_OK : RESP_ERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // read answer registered one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OK;
      end else if (rd_go) begin
         rvalid_q <= 1'b1;
         rdata_q <= rmux;
         rresp_q <= rd_map ? RESP_OK : RESP_ERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_b_q <= 8'h00;
         ctrl_c_q <= CTRL_C_RST;
         baud_q <= BAUD_RST;
         tx_hi_q <= 1'b0;
      end else begin
         if (wr_cb) ctrl_b_q <= wd_q[7:0];
         if (wr_cc) ctrl_c_q <= wd_q[7:0];
         if (wr_bd && ws_q[0]) baud_q[7:0] <= wd_q[7:0];
         if (wr_bd && ws_q[1]) baud_q[15:8] <= wd_q[15:8];
         if (wr_txh) tx_hi_q <= wd_q[0];
      end
   end

   // sample tick divider: one pulse every baud+1 clocks
   always_ff @(posedge aclk) begin
      if (!aresetn || tick) tick_cnt_q <= 16'h0000;
      else tick_cnt_q <= tick_cnt_q + 16'h0001;
   end

   // transmit frame sequencing
   wire [4:0] tx_len = spi ? 5'h02 : smp_per_bit;
   wire tx_bit_end = tick && tx_smp_q == tx_len - 5'h01;
   wire tx_can_load = tx_full_q && tx_on_q;
   wire [8:0] tx_ld = tx_buf_q & dmask;
   wire tx_ld_par = ^tx_ld ^ par_odd;
   wire [3:0] tx_pos = lsb_first ? tx_idx_q : 4'h7 - tx_idx_q;
   // the line shows the next bit on the edge that ends the current one, never on a rising xck
   wire [3:0] tx_idx_nx = (tx_bit_end && tx_st_q == TX_DATA) ? tx_idx_q + 4'h1 : tx_idx_q;
   wire [3:0] tx_pos_nx = lsb_first ? tx_idx_nx : 4'h7 - tx_idx_nx;
   wire tx_last = tx_idx_q == nbits - 4'h1;
   wire tx_frame_end = tx_bit_end && ((tx_st_q == TX_STOP && !tx_stop2_q)
                      || (spi && tx_st_q == TX_DATA && tx_last));
   wire spi_rx_smp = spi && tx_st_q == TX_DATA && tick && tx_smp_q == 5'h00;
   wire tx_load = tx_can_load && (tx_st_q == TX_IDLE || tx_frame_end);

   sftr_tx_t tx_nx;
   always_comb begin
      tx_nx = tx_st_q;
      case (tx_st_q)
         TX_IDLE: if (tx_load) tx_nx = spi ? TX_DATA : TX_START;
         TX_START: if (tx_bit_end) tx_nx = TX_DATA;
         TX_DATA: begin
            if (tx_bit_end && tx_last) tx_nx = spi ? TX_IDLE : par_en ? TX_PAR : TX_STOP;
         end
         TX_PAR: if (tx_bit_end) tx_nx = TX_STOP;
         TX_STOP: if (tx_frame_end) tx_nx = TX_IDLE;
         default: tx_nx = TX_IDLE;
      endcase
      // back-to-back frames skip the idle state entirely
      if (tx_load && tx_st_q != TX_IDLE) tx_nx = spi ? TX_DATA : TX_START;
   end

   // line level for each state; idle and stop bits are high
   logic txd_d;
   always_comb begin
      case (tx_nx)
         TX_START: txd_d = 1'b0;
         TX_DATA: txd_d = tx_load ? (lsb_first ? tx_ld[0] : tx_ld[7]) : tx_sh_q[tx_pos_nx];
         TX_PAR: txd_d = tx_par_q;
         default: txd_d = 1'b1;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_st_q <= TX_IDLE;
         tx_sh_q <= 9'h000;
         tx_par_q <= 1'b0;
         tx_stop2_q <= 1'b0;
         tx_idx_q <= 4'h0;
         tx_smp_q <= 5'h00;
      end else begin
         tx_st_q <= tx_nx;
         if (tx_load) begin
            tx_sh_q <= tx_ld;
            tx_par_q <= tx_ld_par;
            tx_idx_q <= 4'h0;
            tx_smp_q <= 5'h00;
            tx_stop2_q <= 1'b0;
         end else if (tick && tx_st_q != TX_IDLE) begin
            tx_smp_q <= tx_bit_end ? 5'h00 : tx_smp_q + 5'h01;
            if (tx_bit_end && tx_st_q == TX_DATA) tx_idx_q <= tx_idx_q + 4'h1;
            // second stop bit entered when enabled
            if (tx_bit_end && tx_st_q == TX_STOP) tx_stop2_q <= 1'b0;
            else if (tx_bit_end && tx_nx == TX_STOP) tx_stop2_q <= ctrl_c_q[3];
         end
      end
   end

   // transmit buffer, completion flag and deferred disable
   wire txc_set = tx_frame_end && !tx_full_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_buf_q <= 9'h000;
         tx_full_q <= 1'b0;
         txc_q <= 1'b0;
         tx_on_q <= 1'b0;
      end else begin
         if (wr_txl && dre) begin
            tx_buf_q <= {tx_hi_q, wd_q[7:0]};
            tx_full_q <= 1'b1;
         end else if (tx_load) begin
            tx_full_q <= 1'b0;
         end
         // a completion in the same cycle as the clear wins
         if (txc_set) txc_q <= 1'b1;
         else if (wr_st && wd_q[ST_TXC]) txc_q <= 1'b0;
         if (tx_en) tx_on_q <= 1'b1;
         else if (tx_st_q == TX_IDLE && !tx_full_q) tx_on_q <= 1'b0;
      end
   end

   // pin drive; txd_oe follows the transmitter, xck_oe only in spi
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txd_q <= 1'b1;
         xck_q <= 1'b0;
      end else begin
         txd_q <= txd_d;
         xck_q <= spi && tx_nx == TX_DATA && tx_smp_q == 5'h00 && tick && !tx_load;
         if (tx_load) xck_q <= 1'b0;
         else if (!(spi && tick)) xck_q <= xck_q;
      end
   end
   assign txd_o = txd_q;
   assign txd_oe = tx_on_q;
   assign xck_o = xck_q;
   assign xck_oe = tx_on_q && spi;

   // rx pin synchroniser; a change counts once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_sync_q <= 3'h7;
         rx_line_q <= 1'b1;
      end else begin
         rx_sync_q <= {rx_sync_q[1:0], rxd_i};
         if (rx_sync_q[1] == rx_sync_q[2]) rx_line_q <= rx_sync_q[2];
      end
   end

   // receive bit recovery
   wire rx_go = rx_en && !spi;
   wire fall = rx_prev_q && !rx_line_q;
   wire decide = tick && rx_st_q == RX_BIT && rx_smp_q == smp_mid + 5'h02;
   wire vote = (vote_q[0] & vote_q[1]) | (vote_q[0] & rx_line_q)
               | (vote_q[1] & rx_line_q);
   wire [3:0] rx_stop_idx = nbits + {3'h0, par_en} + 4'h1;
   wire rx_is_stop = rx_idx_q == rx_stop_idx;
   wire rx_done = decide && rx_is_stop;
   wire [8:0] rx_m = rx_dat_q & dmask;
   wire par_bad = rx_pbit_q != (^rx_m ^ par_odd);
   wire pid_bad = rx_m[6] != (rx_m[0] ^ rx_m[1] ^ rx_m[2] ^ rx_m[4])
                  || rx_m[7] != !(rx_m[1] ^ rx_m[3] ^ rx_m[4] ^ rx_m[5]);
   wire lin = ctrl_b_q[CB_LIN];
   wire parity_error_flag = lin ? lin_pid_q && pid_bad : par_en && par_bad;

   always_ff @(posedge aclk) begin
      if (!aresetn || !rx_go) begin
         rx_st_q <= RX_IDLE;
         rx_prev_q <= 1'b1;
         rx_smp_q <= 5'h00;
         rx_idx_q <= 4'h0;
         vote_q <= 2'h3;
         rx_dat_q <= 9'h000;
         rx_pbit_q <= 1'b0;
      end else if (tick) begin
         rx_prev_q <= rx_line_q;
         if (rx_smp_q == smp_mid) vote_q[0] <= rx_line_q;
         if (rx_smp_q == smp_mid + 5'h01) vote_q[1] <= rx_line_q;
         case (rx_st_q)
            RX_IDLE: begin
               if (fall) begin
                  rx_st_q <= RX_BIT;
                  rx_smp_q <= 5'h02; // this edge took sample one
                  rx_idx_q <= 4'h0;
               end
            end
            RX_BIT: begin
               rx_smp_q <= rx_smp_q == smp_per_bit ? 5'h01 : rx_smp_q + 5'h01;
               if (rx_smp_q == smp_per_bit) rx_idx_q <= rx_idx_q + 4'h1;
               if (decide) begin
                  if (rx_idx_q == 4'h0 && vote) rx_st_q <= RX_IDLE; // noise spike
                  if (rx_is_stop) rx_st_q <= RX_IDLE;
                  if (rx_idx_q != 4'h0 && rx_idx_q <= nbits) begin
                     rx_dat_q[rx_idx_q - 4'h1] <= vote;
                  end
                  if (par_en && rx_idx_q == nbits + 4'h1) rx_pbit_q <= vote;
               end
            end
            default: rx_st_q <= RX_IDLE;
         endcase
      end
   end

   // spi receive bits are taken on the leading clock edge
   always_ff @(posedge aclk) begin
      if (!aresetn) spi_rx_q <= 8'h00;
      else if (spi_rx_smp) spi_rx_q[tx_pos[2:0]] <= rx_line_q;
   end

   // LIN: the frame after a sync byte is the protected identifier
   always_ff @(posedge aclk) begin
      if (!aresetn || !lin) lin_pid_q <= 1'b0;
      else if (rx_done) lin_pid_q <= rx_m[7:0] == LIN_SYNC;
   end

   // two-entry receive buffer, flags held with each frame
   wire spi_push = rx_en && spi && tx_frame_end;
   wire push = rx_done || spi_push;
   wire [11:0] new_ent = spi_push ? {3'h0, 1'b0, spi_rx_q}
                         : {1'b0, !vote, parity_error_flag, rx_m};
   wire full = cnt_q == 2'h2;
   wire wr_idx = rd_q ^ cnt_q[0];
   always_ff @(posedge aclk) begin
      if (!aresetn || !rx_en) begin
         cnt_q <= 2'h0;
         rd_q <= 1'b0;
         ent_q[0] <= 12'h000;
         ent_q[1] <= 12'h000;
      end else begin
         if (push && !full) ent_q[wr_idx] <= new_ent;
         // full buffer keeps its data; outside spi the newest entry records the loss
         if (push && full && !spi) ent_q[!rd_q][11] <= 1'b1;
         if (pop) rd_q <= !rd_q;
         if (push && !full && !pop) cnt_q <= cnt_q + 2'h1;
         else if (pop && !(push && !full)) cnt_q <= cnt_q - 2'h1;
      end
   end
endmodule
`default_nettype wire

// [include/sftr_pkg.sv]
`default_nettype none
package sftr_pkg;
   localparam logic [7:0] OFS_RX_LOW = 8'h00;
   localparam logic [7:0] OFS_RX_HIGH = 8'h04;
   localparam logic [7:0] OFS_TX_LOW = 8'h08;
   localparam logic [7:0] OFS_TX_HIGH = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_CTRL_B = 8'h14;
   localparam logic [7:0] OFS_CTRL_C = 8'h18;
   localparam logic [7:0] OFS_BAUD = 8'h1C;
   // receive high: data8, parity, frame, overflow, receive complete
   localparam int RH_D8 = 0;
   localparam int RH_PARITY_ERROR_FLAG = 1;
   localparam int RH_FRAME_ERROR_FLAG = 2;
   localparam int RH_OVF = 6;
   localparam int RH_RXC = 7;
   // status bits
   localparam int ST_DRE = 5;
   localparam int ST_TXC = 6;
   localparam int ST_RXC = 7;
   // control_b bits
   localparam int CB_RXEN = 7;
   localparam int CB_TXEN = 6;
   localparam int CB_ONEWIRE = 3;
   localparam int CB_LIN = 2;
   localparam int CB_DBL = 1;
   // control_c: mode [7:6], parity [5:4], two stops 3, size [2:0]
   localparam int CC_ORDER = 2;
   localparam logic [1:0] MODE_SPI = 2'h3;
   localparam logic [1:0] PAR_EVEN = 2'h2;
   localparam logic [1:0] PAR_ODD = 2'h3;
   localparam logic [2:0] SIZE_9 = 3'h7;
   localparam logic [7:0] CTRL_C_RST = 8'h03;
   localparam logic [15:0] BAUD_RST = 16'h0000;
   localparam logic [7:0] LIN_SYNC = 8'h55;
   localparam logic [4:0] SMP_NORM = 5'h10;
   localparam logic [4:0] SMP_DBL = 5'h08;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} sftr_tx_t;
   typedef enum {RX_IDLE, RX_BIT} sftr_rx_t;
endpackage
`default_nettype wire

// [bench/sftr_checker.sv]
`default_nettype none
module sftr_checker
   import sftr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic txd_o,
   input wire logic txd_oe,
   input wire logic xck_o,
   input wire logic xck_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // the pin goes back to the port only while the line rests high
   property p_release_idle; $fell(txd_oe) |-> txd_o; endproperty
   a_release_idle: assert property (p_release_idle)
      else $error("pin released while line low");
   // an async bit lasts eight ticks at least, so no fall is shorter than eight clocks
   property p_bit_len; $fell(txd_o) && !xck_oe |-> !txd_o [*8]; endproperty
   a_bit_len: assert property (p_bit_len)
      else $error("async bit too short");
   // a response only follows once address and data are both held
   property p_aw_busy;
      $rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready);
   endproperty
   a_aw_busy: assert property (p_aw_busy)
      else $error("write response without both channels held");
   property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_r_busy: assert property (p_r_busy)
      else $error("read address ready during response");
   property p_w_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_w_answer: assert property (p_w_answer)
      else $error("write response late");
   property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_answer: assert property (p_r_answer)
      else $error("read response late");
   // unmapped reads answer an error with zero data
   property p_slverr;
      s_axi_arvalid && s_axi_arready && s_axi_araddr[7:5] != 3'h0
         |=> s_axi_rresp == RESP_ERR && s_axi_rdata == 32'h0;
   endproperty
   a_slverr: assert property (p_slverr)
      else $error("unmapped read not refused");
   // the transfer clock rests low whenever the pin is not driven
   property p_xck_own; !xck_oe |-> !xck_o; endproperty
   a_xck_own: assert property (p_xck_own)
      else $error("transfer clock high while not driven");
   property p_xck_spi; $rose(xck_o) |-> xck_oe; endproperty
   a_xck_spi: assert property (p_xck_spi)
      else $error("transfer clock toggles outside spi");
   c_spi: cover property ($rose(xck_o));
   c_frame: cover property ($fell(txd_o) && !xck_oe);
   c_refuse: cover property (s_axi_rvalid && s_axi_rresp == RESP_ERR);
endmodule
bind sftr_engine sftr_checker u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .txd_o(txd_o), .txd_oe(txd_oe), .xck_o(xck_o),
   .xck_oe(xck_oe));
`default_nettype wire

// [bench/sftr_remote.sv]
`default_nettype none
module sftr_remote (
   input wire logic aclk,
   input wire logic txd,
   input wire logic transfer_clock_pin,
   output logic rxd
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] cap_q [$];
   logic [7:0] spi_q;
   logic [9:0] sh;
   initial rxd = 1'b1;
   // remote sender: low start, bits lsb first incl. parity and stop, then idle high
   task automatic send(input logic [9:0] b, input int n, input int len);
      rxd <= 1'b0;
      repeat (len) @(posedge aclk);
      for (int i = 0; i < n; i++) begin
         rxd <= b[i];
         repeat (len) @(posedge aclk);
      end
      rxd <= 1'b1;
      repeat (2 * len) @(posedge aclk);
   endtask
   // short low pulse to probe the start filter
   task automatic glitch(input int n);
      rxd <= 1'b0;
      repeat (n) @(posedge aclk);
      rxd <= 1'b1;
      repeat (200) @(posedge aclk);
   endtask
   // remote receiver: ten bits at bit centres, normal speed only
   initial forever begin
      @(negedge txd);
      repeat (8) @(posedge aclk);
      for (int i = 0; i < 10; i++) begin
         repeat (16) @(posedge aclk);
         sh[i] = txd;
      end
      cap_q.push_back(sh);
   end
   // spi slave shifts in msb first at rising clock
   always @(posedge transfer_clock_pin) spi_q <= {spi_q[6:0], txd};
endmodule
`default_nettype wire

// [bench/serial_frame_tx_rx_engine_tb_top.sv]
`default_nettype none
module serial_frame_tx_rx_engine_tb_top;
   import sftr_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic txd_o, txd_oe, xck_o, xck_oe, rxd;
   int failures = 0, check_count = 0, cyc = 0;
   logic [9:0] fr [3] = '{10'h235, 10'h335, 10'h035};
   logic [7:0] eh [3] = '{8'h80, 8'h82, 8'h84};
   logic [9:0] pid [2] = '{10'h180, 10'h100};
   logic [7:0] ph [2] = '{8'h80, 8'h82};
   logic [9:0] ex [2] = '{10'h235, 10'h307};
   sftr_engine uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .txd_o(txd_o), .txd_oe(txd_oe),
      .rxd_i(rxd), .xck_o(xck_o), .xck_oe(xck_oe));
   sftr_remote rm (.aclk(aclk), .txd(txd_o), .transfer_clock_pin(xck_o), .rxd(rxd));
   always #5 aclk = ~aclk;
   // hang guard, far above the few thousand cycles the sequence needs
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 60000) begin
         failures++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (failures == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   // bready and rready stay high, so the answer edge is also the handshake
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk("rdata", d & m, e);
   endtask
   // poll a status bit, bounded
   task automatic wbit(input logic [7:0] a, input int b);
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 500; i++) begin
         rd(a, d, r);
         if (d[b] === 1'b1) return;
      end
      chk("poll", 32'h0, 32'h1);
   endtask
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [9:0] q;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      // reset values and a refused word
      rchk(OFS_CTRL_C, 32'hFF, 32'(CTRL_C_RST));
      rchk(OFS_CTRL_B, 32'hFF, 32'h0);
      rchk(OFS_STATUS, 32'hE0, 32'h20);
      rd(8'h20, d, r);
      chk("resp", 32'(r), 32'(RESP_ERR));
      w(8'h20, 32'h0);
      chk("bresp", 32'(s_axi_bresp), 32'(RESP_ERR));
      // even parity, second byte queued while the first shifts; bit 8 must vanish
      w(OFS_CTRL_C, 32'({PAR_EVEN, 4'h3}));
      w(OFS_CTRL_B, 32'h40);
      w(OFS_TX_LOW, 32'h35);
      wbit(OFS_STATUS, ST_DRE);
      w(OFS_TX_LOW, 32'h107);
      wbit(OFS_STATUS, ST_TXC);
      chk("frames", 32'(rm.cap_q.size()), 32'h2);
      foreach (ex[i]) begin
         q = rm.cap_q.pop_front();
         chk("txbits", 32'(q), 32'(ex[i]));
      end
      // odd parity with the transmitter switched off before the frame ends
      w(OFS_CTRL_C, 32'({PAR_ODD, 4'h3}));
      w(OFS_TX_LOW, 32'h35);
      w(OFS_CTRL_B, 32'h0);
      chk("oe held", 32'(txd_oe), 32'h1);
      for (int i = 0; i < 400 && txd_oe; i++) @(posedge aclk);
      chk("oe off", 32'(txd_oe), 32'h0);
      q = rm.cap_q.pop_front();
      chk("odd", 32'(q), 32'h335);
      // good, bad parity and low stop frames
      w(OFS_CTRL_C, 32'({PAR_EVEN, 4'h3}));
      w(OFS_CTRL_B, 32'h80);
      for (int i = 0; i < 3; i++) begin
         rm.send(fr[i], 10, 16);
         rchk(OFS_RX_HIGH, 32'hC7, 32'(eh[i]));
         rchk(OFS_RX_LOW, 32'hFF, 32'h35);
      end
      // three frames unread: the third is dropped, newest entry flagged
      rm.send(10'h203, 10, 16);
      rm.send(10'h205, 10, 16);
      rm.send(10'h206, 10, 16);
      rchk(OFS_RX_HIGH, 32'hC7, 32'h80);
      rchk(OFS_RX_LOW, 32'hFF, 32'h03);
      rchk(OFS_RX_HIGH, 32'hC7, 32'hC0);
      rchk(OFS_RX_LOW, 32'hFF, 32'h05);
      rchk(OFS_STATUS, 32'h80, 32'h0);
      // five bits at double speed, then start filter edges
      w(OFS_CTRL_C, 32'h0);
      w(OFS_CTRL_B, 32'h82);
      rm.send(10'h035, 6, 8);
      rchk(OFS_RX_LOW, 32'hFF, 32'h15);
      rm.glitch(3);
      rchk(OFS_STATUS, 32'h80, 32'h0);
      rm.glitch(5);
      rchk(OFS_RX_LOW, 32'hFF, 32'h1F);
      // disable drops the buffered frame
      rm.send(10'h035, 6, 8);
      w(OFS_CTRL_B, 32'h0);
      w(OFS_CTRL_B, 32'h80);
      rchk(OFS_STATUS, 32'h80, 32'h0);
      // lin: only the identifier after the sync byte is checked
      w(OFS_CTRL_C, 32'h03);
      w(OFS_CTRL_B, 32'h84);
      for (int i = 0; i < 2; i++) begin
         rm.send(10'h155, 9, 16);
         rm.send(pid[i], 9, 16);
         rchk(OFS_RX_HIGH, 32'hC7, 32'h80);
         rchk(OFS_RX_LOW, 32'hFF, 32'h55);
         rchk(OFS_RX_HIGH, 32'hC7, 32'(ph[i]));
         rchk(OFS_RX_LOW, 32'hFF, 32'(pid[i][7:0]));
      end
      // nine bits and two stops: the ninth bit goes to the high register first
      w(OFS_CTRL_B, 32'h40);
      w(OFS_CTRL_C, 32'h08 | 32'(SIZE_9));
      w(OFS_STATUS, 32'h40);
      w(OFS_TX_HIGH, 32'h1);
      w(OFS_TX_LOW, 32'h35);
      wbit(OFS_STATUS, ST_TXC);
      q = rm.cap_q.pop_front();
      chk("nine", 32'(q), 32'h335);
      // spi master, both bit orders
      for (int i = 0; i < 2; i++) begin
         w(OFS_CTRL_C, 32'({MODE_SPI, 6'h0}) | (32'(i) << CC_ORDER));
         w(OFS_STATUS, 32'h40);
         w(OFS_TX_LOW, 32'h01);
         wbit(OFS_STATUS, ST_TXC);
         chk("spi", 32'(rm.spi_q), (i == 1) ? 32'h80 : 32'h01);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
